// ==== hw/config_space_index_data.sv ====
// configuration port of the device: index/data pair, chip-level and banked registers
// assumes io cycles from cfg_port_if; RESET_N is the main-supply power-on reset
//
// Design decision made here: the cfg_port_if device port; the AHB-Lite slave port is in cfg_port_host.
`timescale 1ns/10ps
module config_space_index_data #(
	parameter int BANKS = 8
) (
	input  wire logic   CLK,
	input  wire logic   RESET_N,
	input  wire logic   STRAP_SEL,
	input  wire logic   HARD_RESET,
	input  wire logic   STANDBY_POR,
	cfg_port_if.device  port,
	output logic        KBC_RESET,
	output logic        CONFIG_STATE,
	output logic [15:0] CONFIG_BASE
);
	typedef enum logic { RUN_STATE = 1'b0, CFG_STATE = 1'b1 } cfg_state_e;

	// ******************************
	// pin synchronisers
	// ******************************
	logic strap_level;
	logic hard_level;
	logic standby_level;
	logic hard_prev;
	logic standby_prev;

	pin_sync3 u_strap (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.pin     (STRAP_SEL),
		.level   (strap_level)
	);
	pin_sync3 u_hard (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.pin     (HARD_RESET),
		.level   (hard_level)
	);
	pin_sync3 u_standby (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.pin     (STANDBY_POR),
		.level   (standby_level)
	);

	// resets act on their rising edge once synchronised
	wire hard_hit    = hard_level & ~hard_prev;
	wire standby_hit = standby_level & ~standby_prev;

	localparam int BANK_BITS_L = cfg_space_pkg::BANK_BITS;

	// ******************************
	// state
	// ******************************
	cfg_state_e                 state;
	logic [1:0]                 settle;
	logic                       armed;
	logic                       loaded;
	logic [15:0]                base;
	logic [7:0]                 pending_low;
	logic [7:0]                 index;
	logic [BANK_BITS_L-1:0]     bank;
	logic [7:0]                 test_a;
	logic [7:0]                 test_b;
	logic [7:0]                 kbc_test;
	logic [7:0]                 test_c;
	logic [7:0]                 test_d;
	logic [7:0]                 test_e;
	logic [7:0]                 rdata;
	logic                       ack;
	logic [7:0]                 bank_mem [0:BANKS*256-1];

	// ******************************
	// decode
	// ******************************
	wire [15:0] strap_base   = strap_level ? cfg_space_pkg::BASE_STRAP_HIGH
	                                       : cfg_space_pkg::BASE_STRAP_LOW;
	wire        hit_index    = loaded && (port.io_addr == base);
	wire        hit_data     = loaded && (port.io_addr == {base[15:1], 1'b1});
	wire        wr_index     = port.io_wr & hit_index;
	wire        wr_data      = port.io_wr & hit_data;
	wire        rd_any       = port.io_rd & (hit_index | hit_data);
	wire        in_cfg       = (state == CFG_STATE);
	wire        to_bank      = in_cfg && (index >= cfg_space_pkg::IDX_BANK_FIRST);
	wire        chip_wr      = wr_data && in_cfg && !to_bank;
	wire        bank_wr      = wr_data && to_bank;
	wire [BANK_BITS_L+7:0] mem_addr = {bank, index};

	wire [7:0] chip_rdata =
		(index == cfg_space_pkg::IDX_BANK_NUMBER) ? {{(8-BANK_BITS_L){1'b0}}, bank} :
		(index == cfg_space_pkg::IDX_ADDR_LOW)    ? pending_low :
		(index == cfg_space_pkg::IDX_ADDR_HIGH)   ? base[15:8] :
		(index == cfg_space_pkg::IDX_TEST_A)      ? test_a :
		(index == cfg_space_pkg::IDX_TEST_B)      ? test_b :
		(index == cfg_space_pkg::IDX_KBC_TEST)    ? kbc_test :
		(index == cfg_space_pkg::IDX_TEST_C)      ? test_c :
		(index == cfg_space_pkg::IDX_TEST_D)      ? test_d :
		(index == cfg_space_pkg::IDX_TEST_E)      ? test_e : 8'h00;

	// outside configuration state the data port reads as zero
	wire [7:0] data_rdata = !in_cfg ? 8'h00 :
	                        to_bank ? bank_mem[mem_addr] : chip_rdata;
	wire [7:0] next_rdata = hit_index ? index : data_rdata;

	// ******************************
	// base address, strap capture and state
	// ******************************
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			settle       <= 2'h0;
			armed        <= 1'b0;
			loaded       <= 1'b0;
			base         <= 16'h0000;
			pending_low  <= 8'h00;
			hard_prev    <= 1'b0;
			standby_prev <= 1'b0;
		end
		else
		begin
			hard_prev    <= hard_level;
			standby_prev <= standby_level;
			if (settle != cfg_space_pkg::STRAP_SETTLE)
				settle <= settle + 2'h1;
			armed        <= (settle == cfg_space_pkg::STRAP_SETTLE);
			// one cycle after the count ends, so the synced strap level has landed
			if ((armed && !loaded) || hard_hit)
			begin
				loaded      <= 1'b1;
				base        <= strap_base;
				pending_low <= strap_base[7:0];
			end
			else if (chip_wr && index == cfg_space_pkg::IDX_ADDR_LOW)
				pending_low <= {port.io_wdata[7:1], 1'b0};
			else if (chip_wr && index == cfg_space_pkg::IDX_ADDR_HIGH)
				base <= {port.io_wdata, pending_low};
		end
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state <= RUN_STATE;
			index <= 8'h00;
			bank  <= '0;
		end
		else if (hard_hit)
		begin
			state <= RUN_STATE;
			index <= 8'h00;
			bank  <= '0;
		end
		else
		begin
			case (state)
				RUN_STATE:
					if (wr_index && port.io_wdata == cfg_space_pkg::KEY_ENTER)
						state <= CFG_STATE;
				CFG_STATE:
					if (wr_index && port.io_wdata == cfg_space_pkg::KEY_EXIT)
						state <= RUN_STATE;
					else if (wr_index)
						index <= port.io_wdata;
				default:
					state <= RUN_STATE;
			endcase
			if (chip_wr && index == cfg_space_pkg::IDX_BANK_NUMBER)
				bank <= port.io_wdata[BANK_BITS_L-1:0];
		end
	end

	// ******************************
	// factory test and keyboard micro reset
	// ******************************
	// kept writable; the host is expected to leave them alone
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			test_a   <= cfg_space_pkg::TEST_RESET;
			test_b   <= cfg_space_pkg::TEST_RESET;
			kbc_test <= cfg_space_pkg::TEST_RESET;
			test_c   <= cfg_space_pkg::TEST_RESET;
			test_d   <= cfg_space_pkg::TEST_RESET;
			test_e   <= cfg_space_pkg::TEST_RESET;
		end
		else if (standby_hit)
		begin
			test_a   <= cfg_space_pkg::TEST_RESET;
			test_b   <= cfg_space_pkg::TEST_RESET;
			kbc_test <= cfg_space_pkg::TEST_RESET;
			test_c   <= cfg_space_pkg::TEST_RESET;
			test_d   <= cfg_space_pkg::TEST_RESET;
			test_e   <= cfg_space_pkg::TEST_RESET;
		end
		else if (chip_wr)
		begin
			if (index == cfg_space_pkg::IDX_TEST_A)
				test_a <= port.io_wdata;
			if (index == cfg_space_pkg::IDX_TEST_B)
				test_b <= port.io_wdata;
			if (index == cfg_space_pkg::IDX_KBC_TEST)
				kbc_test <= port.io_wdata;
			if (index == cfg_space_pkg::IDX_TEST_C)
				test_c <= port.io_wdata;
			if (index == cfg_space_pkg::IDX_TEST_D)
				test_d <= port.io_wdata;
			if (index == cfg_space_pkg::IDX_TEST_E)
				test_e <= port.io_wdata;
		end
	end

	// ******************************
	// banked storage and answers
	// ******************************
	// no reset on the banks: plain RAM, contents defined by software
	always_ff @(posedge CLK)
	begin
		if (bank_wr)
			bank_mem[mem_addr] <= port.io_wdata;
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rdata        <= 8'h00;
			ack          <= 1'b0;
			KBC_RESET    <= 1'b0;
			CONFIG_STATE <= 1'b0;
			CONFIG_BASE  <= 16'h0000;
		end
		else
		begin
			ack          <= wr_index | wr_data | rd_any;
			if (rd_any)
				rdata <= next_rdata;
			KBC_RESET    <= kbc_test[cfg_space_pkg::KBC_RESET_BIT];
			CONFIG_STATE <= in_cfg;
			CONFIG_BASE  <= base;
		end
	end

	assign port.io_rdata = rdata;
	assign port.io_ack   = ack;
endmodule

// ==== hw/cfg_space_pkg.sv ====
// constants shared by both ends of the configuration port link
// assumes one 10 MHz clock for every module that uses it
package cfg_space_pkg;

	// ******************************
	// chip-level register indexes
	// ******************************
	localparam logic [7:0] IDX_BANK_NUMBER = 8'h07;
	localparam logic [7:0] IDX_ADDR_LOW    = 8'h26;
	localparam logic [7:0] IDX_ADDR_HIGH   = 8'h27;
	localparam logic [7:0] IDX_TEST_A      = 8'h2a;
	localparam logic [7:0] IDX_TEST_B      = 8'h2b;
	localparam logic [7:0] IDX_KBC_TEST    = 8'h2c;
	localparam logic [7:0] IDX_TEST_C      = 8'h2d;
	localparam logic [7:0] IDX_TEST_D      = 8'h2e;
	localparam logic [7:0] IDX_TEST_E      = 8'h2f;
	localparam logic [7:0] IDX_BANK_FIRST  = 8'h30;

	// ******************************
	// fields, keys and reset values
	// ******************************
	localparam int         KBC_RESET_BIT   = 6;
	localparam int         BANK_BITS       = 3;
	localparam logic [7:0] KEY_ENTER       = 8'h55;
	localparam logic [7:0] KEY_EXIT        = 8'haa;
	localparam logic [7:0] TEST_RESET      = 8'h00;
	localparam logic [15:0] BASE_STRAP_LOW  = 16'h002e;
	localparam logic [15:0] BASE_STRAP_HIGH = 16'h004e;
	localparam logic [1:0] STRAP_SETTLE    = 2'h3;

	// ******************************
	// controller registers on the AHB-Lite side
	// ******************************
	localparam logic [7:0] AHB_CMD         = 8'h00;
	localparam logic [7:0] AHB_STATUS      = 8'h04;
	localparam int         CMD_ADDR_LSB    = 0;
	localparam int         CMD_DATA_LSB    = 16;
	localparam int         CMD_WRITE_BIT   = 24;
	localparam int         STAT_BUSY_BIT   = 0;
	localparam int         STAT_TMO_BIT    = 1;
	localparam int         STAT_DATA_LSB   = 8;
	localparam int         IO_TIMEOUT      = 16;

endpackage

// ==== hw/cfg_port_if.sv ====
// one-byte I/O cycles from the host controller to the configuration port
// assumes both ends on the same clock; strobes are single-cycle pulses
`timescale 1ns/10ps
interface cfg_port_if;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_rdata;
	logic        io_ack;

	modport host
	(
		output io_addr,
		output io_wdata,
		output io_wr,
		output io_rd,
		input  io_rdata,
		input  io_ack
	);

	modport device
	(
		input  io_addr,
		input  io_wdata,
		input  io_wr,
		input  io_rd,
		output io_rdata,
		output io_ack
	);
endinterface

// ==== hw/pin_sync3.sv ====
// three-flop synchroniser for a pin; output moves when stages two and three agree
// assumes a pin level asynchronous to CLK
`timescale 1ns/10ps
module pin_sync3 (
	input  wire logic CLK,
	input  wire logic RESET_N,
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level <= s3;
		end
	end
endmodule

// ==== hw/cfg_port_host.sv ====
// host controller: AHB-Lite slave registers that issue io cycles to the port
// assumes a single AHB-Lite master, word transfers only, and the cfg_port_if link
`timescale 1ns/10ps
module cfg_port_host #(
	parameter int TIMEOUT = cfg_space_pkg::IO_TIMEOUT
) (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	cfg_port_if.host         port
);
	typedef enum logic [1:0] { IDLE = 2'b00, STROBE = 2'b01, WAIT = 2'b11 } host_state_e;

	host_state_e state;
	logic        dp_write;
	logic [7:0]  dp_addr;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata;
	logic        io_dir;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  last_rdata;
	logic        timed_out;
	logic [7:0]  wait_cnt;

	// ******************************
	// AHB-Lite decode
	// ******************************
	wire       ap_valid  = HSEL && HREADY && HTRANS[1];
	wire       busy      = (state != IDLE);
	wire       start     = dp_write && dp_addr == cfg_space_pkg::AHB_CMD && !busy;
	wire [31:0] status   = {16'h0000, last_rdata, 6'h00, timed_out, busy};
	wire [31:0] next_rd  = (HADDR[7:0] == cfg_space_pkg::AHB_STATUS) ? status : 32'h0000_0000;
	wire       io_done   = port.io_ack || wait_cnt == TIMEOUT[7:0];

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			dp_write  <= 1'b0;
			dp_addr   <= 8'h00;
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
		else
		begin
			dp_write <= ap_valid && HWRITE;
			dp_addr  <= HADDR[7:0];
			if (ap_valid && !HWRITE)
				HRDATA <= next_rd;
		end
	end

	// ******************************
	// io cycle engine
	// ******************************
	// a command written while busy is dropped
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state      <= IDLE;
			io_addr    <= 16'h0000;
			io_wdata   <= 8'h00;
			io_dir     <= 1'b0;
			io_wr      <= 1'b0;
			io_rd      <= 1'b0;
			last_rdata <= 8'h00;
			timed_out  <= 1'b0;
			wait_cnt   <= 8'h00;
		end
		else
		begin
			io_wr <= 1'b0;
			io_rd <= 1'b0;
			case (state)
				IDLE:
					if (start)
					begin
						io_addr   <= HWDATA[cfg_space_pkg::CMD_ADDR_LSB +: 16];
						io_wdata  <= HWDATA[cfg_space_pkg::CMD_DATA_LSB +: 8];
						io_dir    <= HWDATA[cfg_space_pkg::CMD_WRITE_BIT];
						io_wr     <= HWDATA[cfg_space_pkg::CMD_WRITE_BIT];
						io_rd     <= !HWDATA[cfg_space_pkg::CMD_WRITE_BIT];
						timed_out <= 1'b0;
						wait_cnt  <= 8'h00;
						state     <= STROBE;
					end
				STROBE:
					state <= WAIT;
				WAIT:
				begin
					wait_cnt <= wait_cnt + 8'h01;
					if (io_done)
					begin
						if (port.io_ack && !io_dir)
							last_rdata <= port.io_rdata;
						timed_out <= !port.io_ack;
						state     <= IDLE;
					end
				end
				default:
					state <= IDLE;
			endcase
		end
	end

	assign port.io_addr  = io_addr;
	assign port.io_wdata = io_wdata;
	assign port.io_wr    = io_wr;
	assign port.io_rd    = io_rd;
endmodule

// ==== verif/config_space_index_data_sva.sv ====
// checker for the io link between the host controller and the configuration port
// assumes the bench instantiates it beside the link, all signals on CLK
`timescale 1ns/10ps
module config_space_index_data_sva (
	input wire logic        CLK,
	input wire logic        RESET_N,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_ack,
	input wire logic        KBC_RESET,
	input wire logic        CONFIG_STATE,
	input wire logic [15:0] CONFIG_BASE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	wire logic strobe;
	assign strobe = io_wr || io_rd;

	// ****************
	// properties
	// ****************
	property p_ack_cause;
		io_ack |-> $past(strobe);
	endproperty
	property p_ack_pulse;
		io_ack |=> !io_ack;
	endproperty
	property p_one_strobe;
		!(io_wr && io_rd);
	endproperty
	// host waits for the answer, so strobes never crowd
	property p_strobe_gap;
		strobe |=> !strobe [*2];
	endproperty
	property p_base_even;
		CONFIG_BASE[0] == 1'b0;
	endproperty
	property p_kbc_set;
		$rose(KBC_RESET) |-> ($past(io_ack) || $past(io_ack, 2)) && $past(CONFIG_STATE);
	endproperty
	property p_cfg_enter;
		$rose(CONFIG_STATE) |-> $past(io_ack) || $past(io_ack, 2);
	endproperty
	property p_rdata_hold;
		!$stable(io_rdata) |-> $past(io_rd) || $past(io_rd, 2);
	endproperty

	a_ack_cause:  assert property (p_ack_cause)  else $error("ack without strobe");
	a_ack_pulse:  assert property (p_ack_pulse)  else $error("ack too long");
	a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
	a_base_even:  assert property (p_base_even)  else $error("port address odd");
	a_kbc_set:    assert property (p_kbc_set)    else $error("kbc reset set unasked");
	a_cfg_enter:  assert property (p_cfg_enter)  else $error("config state unasked");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	c_enter: cover property ($rose(CONFIG_STATE));
	c_kbc:   cover property ($rose(KBC_RESET));
	c_move:  cover property (!$stable(CONFIG_BASE));
endmodule

// ==== verif/config_space_index_data_tb_top.sv ====
// self-checking bench: AHB-Lite master, host controller, link and device
// assumes the package and both design ends compiled first
`timescale 1ns/10ps
module config_space_index_data_tb_top;
	logic        CLK = 1'b0;
	logic        RESET_N, STRAP_SEL, HARD_RESET, STANDBY_POR;
	logic        HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
	logic [31:0] HADDR, HWDATA, HRDATA, seed;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic        KBC_RESET, CONFIG_STATE;
	logic [15:0] CONFIG_BASE;
	int          fail_count = 0;
	int          n_checks = 0;
	int          base, cfg, idx, bank, low, i, j, old;
	int          tst[48];
	int          mem[int];

	cfg_port_if link();
	cfg_port_host cfg_port_host_inst (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .port(link));
	config_space_index_data config_space_index_data_inst (.CLK(CLK), .RESET_N(RESET_N),
		.STRAP_SEL(STRAP_SEL), .HARD_RESET(HARD_RESET), .STANDBY_POR(STANDBY_POR),
		.port(link), .KBC_RESET(KBC_RESET), .CONFIG_STATE(CONFIG_STATE),
		.CONFIG_BASE(CONFIG_BASE));
	config_space_index_data_sva config_space_index_data_sva_inst (.CLK(CLK),
		.RESET_N(RESET_N), .io_wr(link.io_wr), .io_rd(link.io_rd), .io_rdata(link.io_rdata),
		.io_ack(link.io_ack), .KBC_RESET(KBC_RESET), .CONFIG_STATE(CONFIG_STATE),
		.CONFIG_BASE(CONFIG_BASE));

	// the one slave's ready is the bus's ready
	assign HREADY = HREADYOUT;

	always #50 CLK = ~CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task summarize();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ****************
	// bus master and reference model
	// ****************
	task ahb(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge CLK);
		HSEL   <= 1'b1;
		HADDR  <= {24'h0, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL   <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask

	task dev(input bit w, input int a, input int d, output int e, output bit hit);
		hit = (a == base) || (a == base + 1);
		e = 0;
		if (hit && a == base)
		begin
			if (!w)
				e = idx;
			else if (!cfg)
				cfg = (d == 8'h55);
			else if (d == 8'haa)
				cfg = 0;
			else
				idx = d;
		end
		else if (hit && cfg)
		begin
			if (idx == 8'h07)
			begin
				if (w) bank = d & 7;
				e = bank;
			end
			else if (idx == 8'h26)
			begin
				if (w) low = d & 8'hfe;
				e = low;
			end
			else if (idx == 8'h27)
			begin
				if (w) base = d * 256 + low;
				e = base >> 8;
			end
			else if (idx >= 8'h30)
			begin
				if (w) mem[bank * 256 + idx] = d;
				e = mem[bank * 256 + idx];
			end
			else
			begin
				if (w) tst[idx] = d;
				e = tst[idx];
			end
		end
	endtask

	// one io cycle via the controller, then compare answer, decode and base
	task io(input bit w, input int a, input int d);
		logic [31:0] r;
		int          e;
		bit          hit;
		int          n;
		dev(w, a, d, e, hit);
		ahb(1'b1, cfg_space_pkg::AHB_CMD, {7'h0, w, d[7:0], a[15:0]}, r);
		n = 0;
		do
		begin
			ahb(1'b0, cfg_space_pkg::AHB_STATUS, 32'h0, r);
			n++;
		end
		while (r[0] !== 1'b0 && n < 100);
		check({31'h0, r[0]}, 32'h0);
		check({31'h0, HRESP}, 32'h0);
		check({31'h0, r[1]}, {31'h0, ~hit});
		if (!w && hit)
			check({24'h0, r[15:8]}, e[7:0]);
		check({16'h0, CONFIG_BASE}, base);
	endtask

	task pulse(input bit hard);
		@(posedge CLK);
		if (hard)
			HARD_RESET <= 1'b1;
		else
			STANDBY_POR <= 1'b1;
		repeat (4) @(posedge CLK);
		HARD_RESET  <= 1'b0;
		STANDBY_POR <= 1'b0;
		repeat (12) @(posedge CLK);
	endtask

	initial
	begin
		repeat (20000) @(posedge CLK);
		fail_count++;
		summarize();
	end

	// ****************
	// main sequence
	// ****************
	initial
	begin
		{RESET_N, HARD_RESET, STANDBY_POR, HSEL, HWRITE, HTRANS} = '0;
		{STRAP_SEL, HSIZE, HADDR, HWDATA} = {1'b1, 3'h2, 64'h0};
		{base, cfg, idx, bank, low, seed} = {32'h4e, 128'h0, 32'h72c7};
		for (i = 0; i < 48; i++) tst[i] = 0;
		repeat (12) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (10) @(posedge CLK);
		check({16'h0, CONFIG_BASE}, base);
		io(1, base, 8'h55);
		for (i = 8'h2a; i <= 8'h2f; i++)
		begin
			io(1, base, i);
			io(0, base + 1, 0);
		end
		io(1, base, 8'h2c);
		io(1, base + 1, 8'h40);
		check({31'h0, KBC_RESET}, 32'h1);
		io(1, base + 1, 8'h00);
		check({31'h0, KBC_RESET}, 32'h0);
		$display("test kbc done");
		for (j = 0; j < 4; j++)
			for (i = 0; i < 8; i++)
			begin
				seed = lfsr(seed);
				io(1, base, 8'h07);
				io(1, base + 1, i);
				io(1, base, j[0] ? 8'hff : 8'h30);
				if (j < 2) io(1, base + 1, seed[7:0]);
				else io(0, base + 1, 0);
			end
		$display("test banks done");
		old = base;
		seed = lfsr(seed);
		io(1, base, 8'h26);
		io(1, base + 1, seed[7:0] | 8'h01);
		io(1, base, 8'h27);
		io(1, base + 1, seed[15:8]);
		io(0, base, 0);
		io(0, base + 1, 0);
		io(0, old, 0);
		$display("test relocate done");
		io(1, base, 8'haa);
		check({31'h0, CONFIG_STATE}, 32'h0);
		io(1, base + 1, 8'h5a);
		io(0, base + 1, 0);
		io(1, base, 8'h55);
		io(1, base, 8'hff);
		io(0, base + 1, 0);
		$display("test state done");
		io(1, base, 8'h2c);
		io(1, base + 1, 8'h40);
		pulse(1'b0);
		for (i = 0; i < 48; i++) tst[i] = 0;
		check({31'h0, KBC_RESET}, 32'h0);
		io(0, base + 1, 0);
		pulse(1'b1);
		{base, cfg, idx, bank} = {32'h4e, 96'h0};
		check({16'h0, CONFIG_BASE}, base);
		check({31'h0, CONFIG_STATE}, 32'h0);
		STRAP_SEL <= 1'b0;
		RESET_N <= 1'b0;
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (10) @(posedge CLK);
		base = 16'h2e;
		io(1, base, 8'h55);
		$display("test resets done");
		summarize();
	end
endmodule
